// ===== design/sts_cfg.svh
// Constants of the scan test controller: register indices, field positions,
// LFSR, signature and wait constants and the host's own bus map.
// Assumes inclusion by bare name from package, interface and modules.
`ifndef STS_CFG_SVH
`define STS_CFG_SVH

`define STS_DATA_W 16
`define STS_ADDR_W 3
`define STS_SR_W 19

`define STS_REG_CONTROL 3'h0
`define STS_REG_STIMULUS 3'h1
`define STS_REG_RESPONSE 3'h2
`define STS_REG_COUNT_A 3'h3
`define STS_REG_COUNT_B 3'h4
`define STS_REG_REPEAT 3'h5
`define STS_REG_SHIFT_CFG 3'h6

`define STS_BIT_BUSY 15
`define STS_BIT_ARMED 14
`define STS_BIT_COMPARE 13
`define STS_BIT_BUS_TEST 12
`define STS_BIT_CORE_TEST 11
`define STS_BIT_QUOT_SEL 10
`define STS_BIT_MUX_SEL 9
`define STS_BIT_ACTIVATE 4
`define STS_BIT_CONT 3
`define STS_BIT_SHIFT 2
`define STS_BIT_AUTO 1
`define STS_BIT_ENTER 0

`define STS_CFG_WAIT_MSB 10
`define STS_CFG_WAIT_LSB 8
`define STS_CFG_STIM_HI_MSB 7
`define STS_CFG_STIM_HI_LSB 5
`define STS_CFG_STIM_LFSR 4
`define STS_CFG_RESP_HI_MSB 3
`define STS_CFG_RESP_HI_LSB 1
`define STS_CFG_RESP_LFSR 0

`define STS_LFSR_TAPS 19'h72000
`define STS_EXPECTED_SIG 19'h00000
`define STS_WAIT_BASE 5'h02

`define STS_AXI_CMD 4'h0
`define STS_AXI_RESULT 4'h4
`define STS_CMD_WRITE_BIT 20
`define STS_CMD_ADDR_MSB 18
`define STS_CMD_ADDR_LSB 16
`define STS_RESULT_BUSY_BIT 16
`define STS_RESP_OKAY 2'h0
`define STS_RESP_SLVERR 2'h2

`endif

// ===== design/sts_pkg.sv
// Types shared by both ends of the scan test controller.
// Assumes sts_cfg.svh for widths.
`include "sts_cfg.svh"

package sts_pkg;

  typedef enum logic [1:0] {
    AUTO_IDLE,
    AUTO_SHIFT,
    AUTO_WAIT
  } sts_auto_state_t;

  typedef struct packed {
    logic armSync1;
    logic armSync2;
    logic extSync1;
    logic extSync2;
    logic ackReg;
    logic [`STS_DATA_W-1:0] rdData;
    logic enterWritten;
    logic enterTest;
    logic busTest;
    logic coreTest;
    logic quotSel;
    logic muxSel;
    logic contBit;
    logic shiftBit;
    logic autoBit;
    logic activateLine;
    logic shifting;
    logic [`STS_SR_W-1:0] stim;
    logic [`STS_SR_W-1:0] resp;
    logic stimLfsr;
    logic respLfsr;
    logic [`STS_DATA_W-1:0] countA;
    logic [`STS_DATA_W-1:0] countB;
    logic [`STS_DATA_W-1:0] cntA;
    logic [`STS_DATA_W-1:0] cntB;
    logic [`STS_DATA_W-1:0] repLoad;
    logic [`STS_DATA_W-1:0] reps;
    logic [2:0] waitSel;
    logic [4:0] waitCnt;
    sts_auto_state_t autoState;
    logic scanOut;
    logic quotOut;
    logic chipResetReq;
  } sts_dev_state_t;

  typedef struct packed {
    logic awReady;
    logic wReady;
    logic awDone;
    logic wDone;
    logic [3:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic req;
    logic write;
    logic [`STS_ADDR_W-1:0] addr;
    logic [`STS_DATA_W-1:0] wrData;
    logic [`STS_DATA_W-1:0] result;
  } sts_host_state_t;

endpackage

// ===== design/sts_if.sv
// Parallel 16-bit register link between the bus master and the test controller.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`include "sts_cfg.svh"

interface sts_if;
  logic regReq;
  logic regWrite;
  logic [`STS_ADDR_W-1:0] regAddr;
  logic [`STS_DATA_W-1:0] regWrData;
  logic regAck;
  logic [`STS_DATA_W-1:0] regRdData;

  modport device (
    input regReq,
    input regWrite,
    input regAddr,
    input regWrData,
    output regAck,
    output regRdData
  );

  modport host (
    output regReq,
    output regWrite,
    output regAddr,
    output regWrData,
    input regAck,
    input regRdData
  );
endinterface

// ===== design/sts_device.sv
// Scan test controller: serial stimulus and response engine with its register file.
// Assumes a bus master on sts_if and a serially scanned unit on the user side.
// Operation
// - Shift stimulus, activate, shift response, latch.
// - Register exchange uses 16-bit parallel words.
// - Serial unit link; response overlaps next stimulus.
// - Deterministic or internally generated pseudorandom stimulus.
// - Compressed response kept as LFSR signature.
// - Uncompressed response latched; master reads each.
// - Manual, automatic and continuous modes exist.
// - Master steps manual mode write-shift-activate-read.
// - Manual mode allows every stimulus/response combination.
// - Automatic mode sequences shifts and activations itself.
// - Continuous mode compresses counter serial output.
// - Stimulus register plain or pattern generator.
// - Response register plain or signature analyser.
// - Any bus master may start automatic runs.
// - Test mode needs pin low and bit.
// - Enter bit takes only first write.
// - Pin release in test mode resets chip.
// - Control register bit layout fixed, 16 bits.
// - Activate bit pulses line, reads zero.
// - Shift ends when both counters reach zero.
// - Auto bit clears when repeats run out.
// - Busy reflects auto, shift or continuous activity.
`timescale 1ns/1ps
`include "sts_cfg.svh"

module sts_device (
  input wire logic core_clk,
  input wire logic nrst,
  sts_if.device bus,
  input wire logic testArmPinN,
  input wire logic scanIn,
  input wire logic extShiftIn,
  input wire logic counterIn,
  output logic scanOut,
  output logic activateLine,
  output logic coreScanLink,
  output logic busTestLink,
  output logic quotientOut,
  output logic testArmed,
  output logic chipResetReq
);

  sts_pkg::sts_dev_state_t stateReg;
  sts_pkg::sts_dev_state_t stateNext;

  assign bus.regAck = stateReg.ackReg;
  assign bus.regRdData = stateReg.rdData;
  assign scanOut = stateReg.scanOut;
  assign activateLine = stateReg.activateLine;
  assign coreScanLink = stateReg.coreTest;
  assign busTestLink = stateReg.busTest;
  assign quotientOut = stateReg.quotOut;
  assign testArmed = stateReg.armSync2;
  assign chipResetReq = stateReg.chipResetReq;

  always_comb begin
    logic take;
    logic [`STS_DATA_W-1:0] wd;
    logic testMode;
    logic autoOn;
    logic lfsrA;
    logic lfsrB;
    logic respBit;
    logic compare;
    logic [`STS_DATA_W-1:0] control;
    take = bus.regReq & ~stateReg.ackReg;
    wd = bus.regWrData;
    testMode = stateReg.enterTest & stateReg.armSync2;
    autoOn = stateReg.autoState != sts_pkg::AUTO_IDLE;
    // Automatic runs always generate and compress, whatever the shift configuration.
    lfsrA = stateReg.stimLfsr | autoOn;
    lfsrB = stateReg.respLfsr | autoOn | stateReg.contBit;
    compare = stateReg.resp == `STS_EXPECTED_SIG;
    respBit = 1'b0;
    control = '0;
    stateNext = stateReg;
    // Pin is active low; armed means held low.
    stateNext.armSync1 = ~testArmPinN;
    stateNext.armSync2 = stateReg.armSync1;
    stateNext.extSync1 = extShiftIn;
    stateNext.extSync2 = stateReg.extSync1;
    stateNext.ackReg = take;
    stateNext.activateLine = 1'b0;
    stateNext.chipResetReq = 1'b0;
    stateNext.quotOut = stateReg.quotSel & stateReg.resp[0];

    // Without the bus-test link, mux select or continuous input the stimulus loops back so the engine can test itself.
    if (stateReg.muxSel) begin
      respBit = stateReg.extSync2;
    end else if (stateReg.contBit && !stateReg.shifting) begin
      respBit = counterIn;
    end else if (stateReg.busTest) begin
      respBit = scanIn;
    end else begin
      respBit = stateReg.stim[0];
    end

    if (stateReg.shifting) begin
      if (stateReg.cntA != '0) begin
        stateNext.scanOut = stateReg.stim[0];
        stateNext.cntA = stateReg.cntA - 16'h0001;
        if (lfsrA) begin
          stateNext.stim = {^(stateReg.stim & `STS_LFSR_TAPS), stateReg.stim[18:1]};
        end else begin
          stateNext.stim = {stateReg.stim[18:16], 1'b0, stateReg.stim[15:1]};
        end
      end
      if (stateReg.cntB != '0) begin
        stateNext.cntB = stateReg.cntB - 16'h0001;
        if (lfsrB) begin
          stateNext.resp = {respBit ^ (^(stateReg.resp & `STS_LFSR_TAPS)),
                            stateReg.resp[18:1]};
        end else begin
          stateNext.resp = {stateReg.resp[18:16], respBit, stateReg.resp[15:1]};
        end
      end
      if (stateReg.cntA == '0 && stateReg.cntB == '0) begin
        stateNext.shifting = 1'b0;
        stateNext.shiftBit = 1'b0;
      end
    end else if (stateReg.contBit) begin
      stateNext.resp = {respBit ^ (^(stateReg.resp & `STS_LFSR_TAPS)),
                        stateReg.resp[18:1]};
    end

    case (stateReg.autoState)
      sts_pkg::AUTO_SHIFT: begin
        if (!stateReg.shifting) begin
          stateNext.activateLine = 1'b1;
          stateNext.waitCnt = {1'b0, stateReg.waitSel, 1'b0} + `STS_WAIT_BASE;
          stateNext.autoState = sts_pkg::AUTO_WAIT;
        end
      end
      sts_pkg::AUTO_WAIT: begin
        if (stateReg.waitCnt > 5'h01) begin
          stateNext.waitCnt = stateReg.waitCnt - 5'h01;
        end else begin
          stateNext.reps = stateReg.reps - 16'h0001;
          if (stateReg.reps == 16'h0001) begin
            stateNext.autoBit = 1'b0;
            stateNext.autoState = sts_pkg::AUTO_IDLE;
          end else begin
            stateNext.shifting = 1'b1;
            stateNext.cntA = stateReg.countA;
            stateNext.cntB = stateReg.countB;
            stateNext.autoState = sts_pkg::AUTO_SHIFT;
          end
        end
      end
      default: begin
      end
    endcase

    // Busy follows the shift and auto engines, not their run bits, which software may clear mid-run.
    control[`STS_BIT_BUSY] = autoOn | stateReg.shifting | stateReg.contBit;
    control[`STS_BIT_ARMED] = stateReg.armSync2;
    control[`STS_BIT_COMPARE] = compare;
    control[`STS_BIT_BUS_TEST] = stateReg.busTest;
    control[`STS_BIT_CORE_TEST] = stateReg.coreTest;
    control[`STS_BIT_QUOT_SEL] = stateReg.quotSel;
    control[`STS_BIT_MUX_SEL] = stateReg.muxSel;
    control[`STS_BIT_CONT] = stateReg.contBit;
    control[`STS_BIT_SHIFT] = stateReg.shiftBit;
    control[`STS_BIT_AUTO] = stateReg.autoBit;
    control[`STS_BIT_ENTER] = stateReg.enterTest;

    if (take && !bus.regWrite) begin
      case (bus.regAddr)
        `STS_REG_CONTROL: stateNext.rdData = control;
        `STS_REG_STIMULUS: stateNext.rdData = stateReg.stim[15:0];
        `STS_REG_RESPONSE: stateNext.rdData = stateReg.resp[15:0];
        `STS_REG_COUNT_A: stateNext.rdData = stateReg.countA;
        `STS_REG_COUNT_B: stateNext.rdData = stateReg.countB;
        `STS_REG_REPEAT: stateNext.rdData = stateReg.reps;
        `STS_REG_SHIFT_CFG: stateNext.rdData = {5'h00, stateReg.waitSel, stateReg.stim[18:16],
                                                stateReg.stimLfsr, stateReg.resp[18:16],
                                                stateReg.respLfsr};
        default: stateNext.rdData = '0;
      endcase
    end

    if (take && bus.regWrite) begin
      case (bus.regAddr)
        `STS_REG_CONTROL: begin
          if (!stateReg.enterWritten) begin
            stateNext.enterWritten = 1'b1;
            stateNext.enterTest = wd[`STS_BIT_ENTER] & stateReg.armSync2;
          end
          if (testMode) begin
            stateNext.busTest = wd[`STS_BIT_BUS_TEST];
            stateNext.coreTest = wd[`STS_BIT_CORE_TEST];
            stateNext.quotSel = wd[`STS_BIT_QUOT_SEL];
            stateNext.muxSel = wd[`STS_BIT_MUX_SEL];
          end
          // A write must not swallow a pulse raised by the automatic sequence.
          stateNext.activateLine = stateNext.activateLine | wd[`STS_BIT_ACTIVATE];
          stateNext.contBit = wd[`STS_BIT_CONT];
          // Clearing the shift or auto bit only changes the readback; engines run on.
          stateNext.shiftBit = wd[`STS_BIT_SHIFT] | (stateReg.shiftBit & stateReg.shifting &
                               wd[`STS_BIT_SHIFT]);
          stateNext.autoBit = wd[`STS_BIT_AUTO] & (autoOn | stateReg.repLoad != '0);
          if (wd[`STS_BIT_SHIFT] && !stateReg.shifting) begin
            stateNext.shifting = 1'b1;
            stateNext.cntA = stateReg.countA;
            stateNext.cntB = stateReg.countB;
          end
          if (wd[`STS_BIT_AUTO] && !autoOn && stateReg.repLoad != '0) begin
            stateNext.reps = stateReg.repLoad;
            stateNext.autoState = sts_pkg::AUTO_SHIFT;
            if (!stateReg.shifting) begin
              stateNext.shifting = 1'b1;
              stateNext.cntA = stateReg.countA;
              stateNext.cntB = stateReg.countB;
            end
          end
        end
        `STS_REG_STIMULUS: stateNext.stim[15:0] = wd;
        `STS_REG_RESPONSE: stateNext.resp[15:0] = wd;
        `STS_REG_COUNT_A: stateNext.countA = wd;
        `STS_REG_COUNT_B: stateNext.countB = wd;
        `STS_REG_REPEAT: stateNext.repLoad = wd;
        `STS_REG_SHIFT_CFG: begin
          stateNext.waitSel = wd[`STS_CFG_WAIT_MSB:`STS_CFG_WAIT_LSB];
          stateNext.stim[18:16] = wd[`STS_CFG_STIM_HI_MSB:`STS_CFG_STIM_HI_LSB];
          stateNext.stimLfsr = wd[`STS_CFG_STIM_LFSR];
          stateNext.resp[18:16] = wd[`STS_CFG_RESP_HI_MSB:`STS_CFG_RESP_HI_LSB];
          stateNext.respLfsr = wd[`STS_CFG_RESP_LFSR];
        end
        default: begin
        end
      endcase
    end

    // Losing the pin in test mode restarts everything, as a chip reset would.
    if (stateReg.enterTest && !stateReg.armSync2) begin
      stateNext = '0;
      stateNext.chipResetReq = 1'b1;
      stateNext.ackReg = take;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

endmodule

// ===== design/sts_host.sv
// Bus master end: takes register orders over AXI4-Lite and runs them on sts_if.
// Assumes a software master on the AXI4-Lite side and the device on sts_if.
`timescale 1ns/1ps
`include "sts_cfg.svh"

module sts_host (
  input wire logic core_clk,
  input wire logic nrst,
  sts_if.host bus,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  sts_pkg::sts_host_state_t stateReg;
  sts_pkg::sts_host_state_t stateNext;

  assign awready = stateReg.awReady;
  assign wready = stateReg.wReady;
  assign bresp = stateReg.bResp;
  assign bvalid = stateReg.bValid;
  assign arready = stateReg.arReady;
  assign rdata = stateReg.rData;
  assign rresp = stateReg.rResp;
  assign rvalid = stateReg.rValid;
  assign bus.regReq = stateReg.req;
  assign bus.regWrite = stateReg.write;
  assign bus.regAddr = stateReg.addr;
  assign bus.regWrData = stateReg.wrData;

  always_comb begin
    stateNext = stateReg;
    if (awvalid && stateReg.awReady) begin
      stateNext.awDone = 1'b1;
      stateNext.awAddr = awaddr[3:0];
    end
    if (wvalid && stateReg.wReady) begin
      stateNext.wDone = 1'b1;
      stateNext.wData = wdata;
      stateNext.wStrb = wstrb;
    end
    if (stateReg.bValid && bready) begin
      stateNext.bValid = 1'b0;
    end
    // The link carries one word at a time; a command while busy is dropped.
    if (stateReg.req && bus.regAck) begin
      stateNext.req = 1'b0;
      if (!stateReg.write) begin
        stateNext.result = bus.regRdData;
      end
    end
    if (stateReg.awDone && stateReg.wDone && !stateReg.bValid) begin
      stateNext.awDone = 1'b0;
      stateNext.wDone = 1'b0;
      stateNext.bValid = 1'b1;
      stateNext.bResp = `STS_RESP_OKAY;
      if (stateReg.awAddr == `STS_AXI_CMD) begin
        if (!stateReg.req && stateReg.wStrb == 4'hF) begin
          stateNext.req = 1'b1;
          stateNext.write = stateReg.wData[`STS_CMD_WRITE_BIT];
          stateNext.addr = stateReg.wData[`STS_CMD_ADDR_MSB:`STS_CMD_ADDR_LSB];
          stateNext.wrData = stateReg.wData[15:0];
        end
      end else if (stateReg.awAddr != `STS_AXI_RESULT) begin
        stateNext.bResp = `STS_RESP_SLVERR;
      end
    end
    stateNext.awReady = ~stateNext.awDone & ~stateNext.bValid;
    stateNext.wReady = ~stateNext.wDone & ~stateNext.bValid;

    if (stateReg.rValid && rready) begin
      stateNext.rValid = 1'b0;
    end
    if (arvalid && stateReg.arReady) begin
      stateNext.rValid = 1'b1;
      stateNext.rResp = `STS_RESP_OKAY;
      case (araddr[3:0])
        `STS_AXI_CMD: stateNext.rData = {11'h000, stateReg.write, 1'b0, stateReg.addr,
                                         stateReg.wrData};
        `STS_AXI_RESULT: stateNext.rData = {15'h0000, stateReg.req, stateReg.result};
        default: begin
          stateNext.rData = 32'h00000000;
          stateNext.rResp = `STS_RESP_SLVERR;
        end
      endcase
    end
    stateNext.arReady = ~stateNext.rValid;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

endmodule

// ===== dv/sts_scan_assertions.sv
// Checker for the register link and the test pins of the scan test controller.
// Assumes instantiation beside the sts_if that joins host and device.
`timescale 1ns/1ps
`include "sts_cfg.svh"

module sts_scan_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [`STS_ADDR_W-1:0] regAddr,
  input wire logic [`STS_DATA_W-1:0] regWrData,
  input wire logic regAck,
  input wire logic [`STS_DATA_W-1:0] regRdData,
  input wire logic testArmPinN,
  input wire logic activateLine,
  input wire logic testArmed,
  input wire logic chipResetReq
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_ack_next: assert property (regReq && !regAck |=> regAck)
    else $error("link request not answered in the next cycle");
  a_ack_pulse: assert property (regAck |=> !regAck)
    else $error("link acknowledge longer than one cycle");
  // A chip reset may clear the read word without a transfer.
  a_rd_hold: assert property ($changed(regRdData) |-> regAck && !regWrite || regRdData == 0)
    else $error("read word changed without a read");
  a_ctl_quiet: assert property (regAck && !regWrite && regAddr == `STS_REG_CONTROL
    |-> regRdData[8:4] == 5'h00)
    else $error("control bits 8 to 4 read nonzero");
  a_act_pulse: assert property (activateLine |=> !activateLine)
    else $error("activate line held too long");
  a_act_cause: assert property (regReq && !regAck && regWrite && regAddr == `STS_REG_CONTROL
    && regWrData[`STS_BIT_ACTIVATE] |-> ##[1:2] activateLine)
    else $error("activate write gave no pulse");
  a_arm_low: assert property (!testArmPinN [*5] |-> testArmed)
    else $error("armed status missing with pin low");
  a_arm_high: assert property (testArmPinN [*5] |-> !testArmed)
    else $error("armed status with pin high");
  a_rst_cause: assert property (chipResetReq |-> testArmPinN || $past(testArmPinN)
    || $past(testArmPinN, 2) || $past(testArmPinN, 3))
    else $error("chip reset without pin release");
  a_rst_pulse: assert property (chipResetReq |=> !chipResetReq)
    else $error("chip reset request held too long");
endmodule

// ===== dv/scan_test_submodule_test.sv
// Self-checking bench: AXI4-Lite master on the host, scan pins on the device.
// Assumes sts_host and sts_device joined by sts_if on one 50 MHz clock.
`timescale 1ns/1ps
`include "sts_cfg.svh"

module scan_test_submodule_test;
  logic core_clk = 1'b0;
  logic nrst, testArmPinN, scanIn, counterIn;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic activateLine, testArmed, chipResetReq, coreScanLink, busTestLink, scanOut;
  logic [15:0] rnd = 16'h3E9C;
  int n_fail = 0;
  int compares = 0;
  int acts = 0;
  int rsts = 0;

  sts_if link();
  sts_host sts_host_inst (.core_clk(core_clk), .nrst(nrst), .bus(link), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  sts_device sts_device_inst (.core_clk(core_clk), .nrst(nrst), .bus(link),
    .testArmPinN(testArmPinN), .scanIn(scanIn), .extShiftIn(1'b0), .counterIn(counterIn),
    .scanOut(scanOut), .activateLine(activateLine), .coreScanLink(coreScanLink),
    .busTestLink(busTestLink), .quotientOut(), .testArmed(testArmed),
    .chipResetReq(chipResetReq));
  sts_scan_assertions sts_scan_assertions_inst (.core_clk(core_clk), .nrst(nrst),
    .regReq(link.regReq), .regWrite(link.regWrite), .regAddr(link.regAddr),
    .regWrData(link.regWrData), .regAck(link.regAck), .regRdData(link.regRdData),
    .testArmPinN(testArmPinN), .activateLine(activateLine), .testArmed(testArmed),
    .chipResetReq(chipResetReq));

  always #10 core_clk = ~core_clk;

  function automatic logic [15:0] nxt(input logic [15:0] r);
    return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
  endfunction

  // Response input is stim[0] while the bus-test link and mux select are off.
  // The top bit returned is the last bit put on the scan output.
  function automatic logic [38:0] sh(input logic [18:0] s, input logic [18:0] r,
    input logic ls, input logic lr, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      b = s[0];
      s = ls ? {^(s & `STS_LFSR_TAPS), s[18:1]} : {s[18:16], 1'b0, s[15:1]};
      r = lr ? {^(r & `STS_LFSR_TAPS) ^ b, r[18:1]} : {r[18:16], b, r[15:1]};
    end
    return {b, s, r};
  endfunction

  always @(posedge core_clk) begin
    rnd <= nxt(rnd);
    scanIn <= rnd[0];
    counterIn <= rnd[5];
    if (activateLine === 1'b1) acts <= acts + 1;
    if (chipResetReq === 1'b1) rsts <= rsts + 1;
  end

  task automatic wrap_up;
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    rs = rresp;
  endtask

  // One link transfer: command word, then poll until the link is free.
  task automatic lk(input logic wr, input logic [2:0] idx, input logic [15:0] d,
    output logic [15:0] q);
    logic [31:0] v;
    logic [1:0] rs;
    axw({28'h0, `STS_AXI_CMD}, {11'h000, wr, 1'b0, idx, d}, rs);
    do axr({28'h0, `STS_AXI_RESULT}, v, rs); while (v[`STS_RESULT_BUSY_BIT] !== 1'b0);
    q = v[15:0];
  endtask

  task automatic w(input logic [2:0] idx, input logic [15:0] d);
    logic [15:0] q;
    lk(1'b1, idx, d, q);
  endtask

  task automatic run(input logic [15:0] cfg, input logic [15:0] seed, input int n,
    input logic [15:0] ctl, input int rounds);
    logic [15:0] q;
    logic [38:0] m;
    w(`STS_REG_SHIFT_CFG, cfg);
    w(`STS_REG_STIMULUS, seed);
    w(`STS_REG_COUNT_A, 16'(n));
    w(`STS_REG_COUNT_B, 16'(n));
    w(`STS_REG_REPEAT, 16'(rounds));
    lk(1'b0, `STS_REG_RESPONSE, 16'h0000, q);
    m = sh({3'h0, seed}, {3'h0, q}, cfg[4] | ctl[1], cfg[0] | ctl[1], n * rounds);
    w(`STS_REG_CONTROL, ctl);
    lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    if (ctl[1]) chk("auto busy", 2'b11, {q[15], q[1]});
    while (q[2:1] !== 2'b00) lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    lk(1'b0, `STS_REG_RESPONSE, 16'h0000, q);
    chk("response", m[15:0], q);
    lk(1'b0, `STS_REG_STIMULUS, 16'h0000, q);
    chk("stimulus", m[34:19], q);
    chk("scan out", m[38], scanOut);
    w(`STS_REG_CONTROL, 16'h0010);
  endtask

  initial begin
    logic [15:0] q;
    logic [31:0] v;
    logic [1:0] rs;
    nrst = 1'b0;
    testArmPinN = 1'b1;
    scanIn = 1'b0;
    counterIn = 1'b0;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    chk("control reset", 16'h2000, q);
    lk(1'b0, 3'h7, 16'h0000, q);
    chk("unmapped read", 16'h0000, q);
    axr(32'h8, v, rs);
    chk("bad read", `STS_RESP_SLVERR, rs);
    axw(32'h8, 32'h0, rs);
    chk("bad write", `STS_RESP_SLVERR, rs);
    w(`STS_REG_CONTROL, 16'h0000);
    testArmPinN <= 1'b0;
    repeat (6) @(posedge core_clk);
    w(`STS_REG_CONTROL, 16'h1E01);
    lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    chk("locked control", 16'h4000, q & 16'hDFFF);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    w(`STS_REG_CONTROL, 16'hBFF1);
    // The scan link bits are writable only once test mode is already on.
    w(`STS_REG_CONTROL, 16'h1E01);
    lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    chk("test control", 16'h5E01, q & 16'hDFFF);
    chk("scan links", 2'b11, {busTestLink, coreScanLink});
    testArmPinN <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("chip resets", 1, rsts);
    lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    chk("control after exit", 16'h0000, q & 16'hDFFF);
    for (int i = 0; i < 4; i++) begin
      run({11'h000, i[1], 3'h0, i[0]}, rnd, 1 + int'(rnd[11:8]), 16'h0004, 1);
    end
    run(16'h0711, rnd, 16, 16'h0002, 2);
    lk(1'b0, `STS_REG_REPEAT, 16'h0000, q);
    chk("repeat count", 16'h0000, q);
    repeat (4) @(posedge core_clk);
    chk("activate pulses", 8, acts);
    w(`STS_REG_CONTROL, 16'h0008);
    lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    chk("continuous busy", 2'b11, {q[15], q[3]});
    w(`STS_REG_CONTROL, 16'h0000);
    lk(1'b0, `STS_REG_CONTROL, 16'h0000, q);
    chk("idle busy", 1'b0, q[15]);
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end
endmodule
